// ==== src/sdb_pkg.sv ====
package sdb_pkg;
    localparam int ADDR_W = 14;
    localparam int COL_W = 10;
    localparam int BA_W = 2;
    localparam int PIN_W = 1 + 4 + BA_W + ADDR_W;
    // timing in ns as specified, cycle counts derived at 50 ns per clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_INIT_NS = 200000;
    localparam int T_RP_NS = 30;
    localparam int T_RFC_NS = 110;
    localparam int T_MRD_NS = 20;
    localparam int CNT_W = 12;
    function automatic logic [CNT_W-1:0] sdb_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1)
        begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction : sdb_cycles
    localparam logic [CNT_W-1:0] INIT_CYC = sdb_cycles(T_INIT_NS);
    localparam logic [CNT_W-1:0] RP_CYC = sdb_cycles(T_RP_NS);
    localparam logic [CNT_W-1:0] RFC_CYC = sdb_cycles(T_RFC_NS);
    localparam logic [CNT_W-1:0] MRD_CYC = sdb_cycles(T_MRD_NS);
    // command code {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MODE = 4'h0;
    localparam logic [3:0] CMD_RFSH = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam int CS_BIT = 3;
    localparam int ALLBANK_BIT = 10;
    localparam logic [BA_W-1:0] BA_MODE = 2'h0;
    localparam logic [BA_W-1:0] BA_EXT = 2'h2;
    // standard mode register fields
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int OPM_LSB = 7;
    localparam logic [2:0] BL2 = 3'h1;
    localparam logic [2:0] BL4 = 3'h2;
    localparam logic [2:0] BL8 = 3'h3;
    localparam logic [2:0] BL16 = 3'h4;
    localparam logic [2:0] CL2 = 3'h2;
    localparam logic [2:0] CL3 = 3'h3;
    localparam logic [ADDR_W-1:0] MODE_RESET = 14'h0000;
    // register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MODE = 8'h08;
    localparam logic [7:0] REG_EXT = 8'h0c;
    localparam logic [7:0] REG_BURST = 8'h10;
    localparam int CTRL_REINIT = 0;
    localparam int CTRL_CLRERR = 1;
    localparam int ST_READY = 0;
    localparam int ST_BURST = 1;
    localparam int ST_GOTMODE = 2;
    localparam int ST_GOTEXT = 3;
    localparam int ST_RESVERR = 4;
    localparam int ST_TIMEERR = 5;
    localparam int ST_SEQERR = 6;
    localparam int ST_DEEPPD = 7;
    typedef enum logic [2:0] {
        SDB_STARTUP, SDB_PRECHG, SDB_REF1, SDB_REF2, SDB_MODES, SDB_READY,
        SDB_DEEPPD
    } sdb_init_t;
endpackage : sdb_pkg

// ==== src/sdb_burst_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface sdb_burst_if;
    logic [3:0] startLow;
    logic [3:0] step;
    logic [2:0] lenCode;
    logic interleaved;
    logic [3:0] offset;
    logic [3:0] lenMask;
    modport seq (output startLow, step, lenCode, interleaved,
                 input offset, lenMask);
    modport calc (input startLow, step, lenCode, interleaved,
                  output offset, lenMask);
endinterface : sdb_burst_if
`default_nettype wire

// ==== src/sdb_burst_order.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdb_burst_order (
    sdb_burst_if.calc bus // burst ordering request and answer
);
    import sdb_pkg::*;
    always_comb
    begin
        case (bus.lenCode)
            BL2: bus.lenMask = 4'h1;
            BL4: bus.lenMask = 4'h3;
            BL8: bus.lenMask = 4'h7;
            BL16: bus.lenMask = 4'hf;
            default: bus.lenMask = 4'h1;
        endcase
        // offset stays inside the aligned block and wraps
        if (bus.interleaved)
        begin
            bus.offset = (bus.startLow ^ bus.step) & bus.lenMask;
        end
        else
        begin
            bus.offset = 4'(bus.startLow + bus.step) & bus.lenMask;
        end
    end
endmodule : sdb_burst_order
`default_nettype wire

// ==== src/sdb_init_mode.sv ====
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module sdb_init_mode (
    input wire logic clk, // 20 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic cke, // memory clock enable pin
    input wire logic [3:0] cmdPins, // {cs_n, ras_n, cas_n, we_n}
    input wire logic [sdb_pkg::BA_W-1:0] bankAddr, // bank address pins
    input wire logic [sdb_pkg::ADDR_W-1:0] addrPins, // address pins
    output logic initDone, // initialization complete
    output logic burstValid, // burst column valid this cycle
    output logic [sdb_pkg::COL_W-1:0] burstCol, // current burst column
    output logic [2:0] read_latency_cycles // programmed read latency
);
    import sdb_pkg::*;

    // pin synchronisers
    logic [PIN_W-1:0] pinS1_reg, pinS2_reg, pinS3_reg, pinAcc_reg;
    logic [PIN_W-1:0] pinS1_next, pinS2_next, pinS3_next, pinAcc_next;
    logic ckePrev_reg, ckePrev_next;
    logic newCmd, pinCke;
    logic [3:0] pinCmd;
    logic [BA_W-1:0] pinBa;
    logic [ADDR_W-1:0] pinAddr;
    always_comb
    begin
        pinS1_next = {cke, cmdPins, bankAddr, addrPins};
        pinS2_next = pinS1_reg;
        pinS3_next = pinS2_reg;
        pinAcc_next = (pinS2_reg == pinS3_reg) ? pinS3_reg : pinAcc_reg;
        // decode the value taken at this edge, not the one before it
        {pinCke, pinCmd, pinBa, pinAddr} = pinAcc_next;
        newCmd = (pinS2_reg == pinS3_reg) && (pinS3_reg != pinAcc_reg);
        ckePrev_next = pinCke;
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pinS1_reg <= '0;
            pinS2_reg <= '0;
            pinS3_reg <= '0;
            pinAcc_reg <= '0;
            ckePrev_reg <= 1'b0;
        end
        else
        begin
            pinS1_reg <= pinS1_next;
            pinS2_reg <= pinS2_next;
            pinS3_reg <= pinS3_next;
            pinAcc_reg <= pinAcc_next;
            ckePrev_reg <= ckePrev_next;
        end
    end

    // decoded command, one per accepted change of the pins
    logic exec, isModeLd, isPre, isRfsh, isRdWr, dpdEntry, dpdExit;
    logic modeOk;
    always_comb
    begin
        // clock enable low holds the device idle
        exec = pinCke && ckePrev_reg && newCmd && !pinCmd[CS_BIT]
            && (pinCmd != CMD_NOP);
        isModeLd = exec && (pinCmd == CMD_MODE);
        isPre = exec && (pinCmd == CMD_PRE) && pinAddr[ALLBANK_BIT];
        isRfsh = exec && (pinCmd == CMD_RFSH);
        isRdWr = exec && ((pinCmd == CMD_READ) || (pinCmd == CMD_WRITE));
        dpdEntry = newCmd && !pinCke && ckePrev_reg
            && (pinCmd == CMD_BST);
        dpdExit = pinCke && !ckePrev_reg;
        modeOk = (pinAddr[ADDR_W-1:OPM_LSB] == '0)
            && (pinAddr[BL_LSB+:3] >= BL2)
            && (pinAddr[BL_LSB+:3] <= BL16)
            && ((pinAddr[CL_LSB+:3] == CL2)
            || (pinAddr[CL_LSB+:3] == CL3));
    end

    // initialization tracker and mode registers
    sdb_init_t state_reg, state_next;
    logic [CNT_W-1:0] wait_reg, wait_next;
    logic gotMode_reg, gotMode_next, gotExt_reg, gotExt_next;
    logic [ADDR_W-1:0] mode_reg, mode_next, ext_reg, ext_next;
    logic reinit, clrErr, busy;
    logic timeErr_reg, timeErr_next, seqErr_reg, seqErr_next;
    logic resvErr_reg, resvErr_next;
    logic setTime, setSeq, setResv, loadMode;
    always_comb
    begin
        state_next = state_reg;
        wait_next = (wait_reg != '0) ? wait_reg - 1'b1 : wait_reg;
        gotMode_next = gotMode_reg;
        gotExt_next = gotExt_reg;
        mode_next = mode_reg;
        ext_next = ext_reg;
        setTime = exec && (wait_reg != '0);
        setSeq = 1'b0;
        setResv = 1'b0;
        loadMode = isModeLd && (pinBa == BA_MODE);
        case (state_reg)
            SDB_STARTUP:
            begin
                if (exec)
                begin
                    setSeq = !isPre;
                    state_next = isPre ? SDB_REF1 : SDB_STARTUP;
                    wait_next = isPre ? RP_CYC : wait_reg;
                end
            end
            SDB_REF1, SDB_REF2:
            begin
                if (exec)
                begin
                    setSeq = !isRfsh && !isPre;
                    if (isRfsh)
                    begin
                        state_next = (state_reg == SDB_REF1) ? SDB_REF2
                            : SDB_MODES;
                        wait_next = RFC_CYC;
                    end
                    else if (isPre)
                    begin
                        wait_next = RP_CYC;
                    end
                end
            end
            SDB_MODES, SDB_READY:
            begin
                if (state_reg == SDB_MODES && gotMode_reg && gotExt_reg
                    && wait_reg == '0)
                begin
                    state_next = SDB_READY;
                end
                if (state_reg == SDB_MODES && exec && !isModeLd)
                begin
                    setSeq = 1'b1;
                end
                if (isModeLd && busy)
                begin
                    setSeq = 1'b1;
                end
                if (loadMode)
                begin
                    if (modeOk)
                    begin
                        mode_next = pinAddr;
                        gotMode_next = 1'b1;
                    end
                    else
                    begin
                        setResv = 1'b1;
                    end
                    wait_next = MRD_CYC;
                end
                else if (isModeLd && pinBa == BA_EXT)
                begin
                    ext_next = pinAddr;
                    gotExt_next = 1'b1;
                    wait_next = MRD_CYC;
                end
                if (dpdEntry && state_reg == SDB_READY)
                begin
                    state_next = SDB_DEEPPD;
                    mode_next = MODE_RESET;
                    ext_next = MODE_RESET;
                    gotMode_next = 1'b0;
                    gotExt_next = 1'b0;
                end
            end
            SDB_DEEPPD:
            begin
                if (dpdExit)
                begin
                    state_next = SDB_STARTUP; // full init again
                    wait_next = INIT_CYC;
                end
            end
            default:
            begin
                state_next = SDB_STARTUP;
            end
        endcase
        if (reinit)
        begin
            // software power-cycle model: restart the sequence
            state_next = SDB_STARTUP;
            wait_next = INIT_CYC;
            gotMode_next = 1'b0;
            gotExt_next = 1'b0;
            mode_next = MODE_RESET;
            ext_next = MODE_RESET;
        end
        // a new error beats a clear in the same cycle
        timeErr_next = (timeErr_reg && !clrErr) || setTime;
        seqErr_next = (seqErr_reg && !clrErr) || setSeq;
        resvErr_next = (resvErr_reg && !clrErr) || setResv;
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= SDB_STARTUP;
            wait_reg <= INIT_CYC;
            gotMode_reg <= 1'b0;
            gotExt_reg <= 1'b0;
            mode_reg <= MODE_RESET;
            ext_reg <= MODE_RESET;
            timeErr_reg <= 1'b0;
            seqErr_reg <= 1'b0;
            resvErr_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            gotMode_reg <= gotMode_next;
            gotExt_reg <= gotExt_next;
            mode_reg <= mode_next;
            ext_reg <= ext_next;
            timeErr_reg <= timeErr_next;
            seqErr_reg <= seqErr_next;
            resvErr_reg <= resvErr_next;
        end
    end

    // burst column sequencer
    sdb_burst_if burstBus ();
    sdb_burst_order ordering (.bus(burstBus));
    logic [COL_W-1:0] start_reg, start_next, col_reg, col_next;
    logic [3:0] step_reg, step_next;
    logic active_reg, active_next, valid_reg, valid_next;
    logic [2:0] lat_reg, lat_next;
    logic ready_reg, ready_next;
    assign busy = active_reg;
    always_comb
    begin
        burstBus.startLow = start_reg[3:0];
        burstBus.step = step_reg;
        burstBus.lenCode = mode_reg[BL_LSB+:3];
        burstBus.interleaved = mode_reg[BT_BIT];
        start_next = start_reg;
        step_next = step_reg;
        active_next = active_reg;
        col_next = col_reg;
        valid_next = active_reg;
        if (active_reg)
        begin
            col_next = (start_reg & ~COL_W'(burstBus.lenMask))
                | COL_W'(burstBus.offset);
            step_next = step_reg + 1'b1;
            active_next = (step_reg != burstBus.lenMask);
        end
        if (isRdWr && ready_reg)
        begin
            // a new read or write truncates any burst in flight
            start_next = pinAddr[COL_W-1:0];
            step_next = '0;
            active_next = 1'b1;
        end
        if (state_next != SDB_READY)
        begin
            active_next = 1'b0;
        end
        lat_next = mode_reg[CL_LSB+:3];
        ready_next = (state_reg == SDB_READY);
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            start_reg <= '0;
            step_reg <= '0;
            active_reg <= 1'b0;
            col_reg <= '0;
            valid_reg <= 1'b0;
            lat_reg <= '0;
            ready_reg <= 1'b0;
        end
        else
        begin
            start_reg <= start_next;
            step_reg <= step_next;
            active_reg <= active_next;
            col_reg <= col_next;
            valid_reg <= valid_next;
            lat_reg <= lat_next;
            ready_reg <= ready_next;
        end
    end

    // wishbone slave, answers one cycle after the strobe
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [7:0] status;
    logic wrCtrl;
    always_comb
    begin
        status = '0;
        status[ST_READY] = ready_reg;
        status[ST_BURST] = active_reg;
        status[ST_GOTMODE] = gotMode_reg;
        status[ST_GOTEXT] = gotExt_reg;
        status[ST_RESVERR] = resvErr_reg;
        status[ST_TIMEERR] = timeErr_reg;
        status[ST_SEQERR] = seqErr_reg;
        status[ST_DEEPPD] = (state_reg == SDB_DEEPPD);
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        wrCtrl = ack_next && wb_we_i && (wb_adr_i == REG_CTRL)
            && wb_sel_i[0];
        reinit = wrCtrl && wb_dat_i[CTRL_REINIT];
        clrErr = wrCtrl && wb_dat_i[CTRL_CLRERR];
        rdat_next = '0;
        if (ack_next && !wb_we_i)
        begin
            case (wb_adr_i)
                REG_STATUS: rdat_next = 32'(status);
                REG_MODE: rdat_next = 32'(mode_reg);
                REG_EXT: rdat_next = 32'(ext_reg);
                REG_BURST: rdat_next = 32'(col_reg);
                default: rdat_next = '0;
            endcase
        end
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
        end
        else
        begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign initDone = ready_reg;
    assign burstValid = valid_reg;
    assign burstCol = col_reg;
    assign read_latency_cycles = lat_reg;
endmodule : sdb_init_mode
`default_nettype wire

// ==== verif/sdb_init_mode_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdb_init_mode_asserts
    import sdb_pkg::*;
(
    input wire logic clk, // clock
    input wire logic reset, // synchronous reset
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_ack_o, // bus acknowledge
    input wire logic cke, // clock enable pin
    input wire logic [3:0] cmdPins, // command pins
    input wire logic [sdb_pkg::BA_W-1:0] bankAddr, // bank pins
    input wire logic [sdb_pkg::ADDR_W-1:0] addrPins, // address pins
    input wire logic initDone, // init complete
    input wire logic burstValid, // burst column valid
    input wire logic [sdb_pkg::COL_W-1:0] burstCol, // burst column
    input wire logic [2:0] read_latency_cycles // read latency
);
    logic [6:0] mode_reg, mode_next;
    logic [5:0] modeAge_reg, modeAge_next;
    logic [12:0] wakeAge_reg, wakeAge_next;
    logic ckePrev_reg;
    logic [4:0] kCnt_reg, kCnt_next;
    logic [9:0] start_reg, start_next;
    logic modeLdOk;
    logic [4:0] blen;
    logic [9:0] mask, expCol;
    // shadow of the last legal mode load seen on the raw pins
    always_comb
    begin
        modeLdOk = cke && cmdPins == CMD_MODE && bankAddr == BA_MODE
            && addrPins[13:7] == 7'h00 && addrPins[2:0] inside {[BL2:BL16]}
            && addrPins[6:4] inside {CL2, CL3};
        mode_next = modeLdOk ? addrPins[6:0] : mode_reg;
        modeAge_next = modeLdOk ? 6'h00
            : modeAge_reg + {5'h00, modeAge_reg != 6'h3f};
        wakeAge_next = (cke && !ckePrev_reg) ? 13'h0000
            : wakeAge_reg + {12'h000, !wakeAge_reg[12]};
        kCnt_next = burstValid ? kCnt_reg + 5'h01 : 5'h00;
        start_next = (burstValid && kCnt_reg == 5'h00) ? burstCol : start_reg;
        blen = 5'h01 << mode_reg[2:0];
        mask = {5'h00, blen - 5'h01};
        expCol = mode_reg[BT_BIT] ? start_reg ^ {5'h00, kCnt_reg}
            : (start_reg & ~mask) | ((start_reg + {5'h00, kCnt_reg}) & mask);
    end
    always_ff @(posedge clk)
    begin
        mode_reg <= reset ? 7'h00 : mode_next;
        modeAge_reg <= reset ? 6'h3f : modeAge_next;
        wakeAge_reg <= reset ? 13'h0000 : wakeAge_next;
        ckePrev_reg <= cke;
        kCnt_reg <= reset ? 5'h00 : kCnt_next;
        start_reg <= start_next;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack late after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    burst_ready_a: assert property (burstValid |-> initDone)
        else $error("burst before init complete");
    burst_len_a: assert property ($fell(burstValid) |-> kCnt_reg == blen)
        else $error("burst shorter than burst length");
    burst_max_a: assert property (burstValid |-> kCnt_reg < blen)
        else $error("burst longer than burst length");
    order_seq_a: assert property (
        burstValid && kCnt_reg != 5'h00 && !mode_reg[BT_BIT]
        |-> burstCol == expCol) else $error("sequential column wrong");
    order_intl_a: assert property (
        burstValid && kCnt_reg != 5'h00 && mode_reg[BT_BIT]
        |-> burstCol == expCol) else $error("interleaved column wrong");
    latency_mode_a: assert property (
        initDone && modeAge_reg > 6'h10
        |-> read_latency_cycles == mode_reg[6:4])
        else $error("latency differs from loaded mode");
    latency_hold_a: assert property (
        $changed(read_latency_cycles) && read_latency_cycles != 3'h0
        |-> modeAge_reg < 6'h0c) else $error("latency changed unasked");
    init_wait_a: assert property (
        $rose(initDone) |-> wakeAge_reg > 13'h0fa0)
        else $error("init done before startup wait");
    cover property (burstValid && mode_reg[BT_BIT] && blen == 5'h10);
    cover property ($rose(initDone));
    cover property ($fell(initDone));
endmodule : sdb_init_mode_asserts
bind sdb_init_mode sdb_init_mode_asserts sdb_init_mode_asserts_inst (
    .clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cke, .cmdPins,
    .bankAddr, .addrPins, .initDone, .burstValid, .burstCol,
    .read_latency_cycles);
`default_nettype wire

// ==== verif/sdb_ctl_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdb_ctl_model
    import sdb_pkg::*;
(
    input wire logic clk, // memory clock
    output var logic cke, // clock enable
    output var logic [3:0] cmdPins, // command pins
    output var logic [sdb_pkg::BA_W-1:0] bankAddr, // bank pins
    output var logic [sdb_pkg::ADDR_W-1:0] addrPins // address pins
);
    initial
    begin
        cke = 1'b1;
        cmdPins = CMD_NOP;
        bankAddr = 2'h0;
        addrPins = 14'h0000;
    end
    // held two edges for the synchroniser, then bus released inverted
    task automatic send(input logic [3:0] c, input logic [1:0] b,
        input logic [13:0] a, input int gap);
        @(posedge clk);
        cmdPins <= c;
        bankAddr <= b;
        addrPins <= a;
        repeat (2) @(posedge clk);
        cmdPins <= CMD_NOP;
        bankAddr <= ~b;
        addrPins <= ~a;
        repeat (gap + 4) @(posedge clk);
    endtask : send
    task automatic init(input int slow);
        @(posedge clk);
        cke <= 1'b1;
        repeat (4020 + slow) @(posedge clk);
        send(CMD_PRE, 2'h0, 14'h0400, int'(RP_CYC) + slow);
        send(CMD_RFSH, 2'h0, 14'h0000, int'(RFC_CYC) + slow);
        send(CMD_RFSH, 2'h0, 14'h0000, int'(RFC_CYC) + slow);
        send(CMD_MODE, BA_EXT, 14'h0000, int'(MRD_CYC) + slow);
    endtask : init
    task automatic deep_pd;
        @(posedge clk);
        cke <= 1'b0;
        cmdPins <= CMD_BST;
        repeat (2) @(posedge clk);
        cmdPins <= CMD_NOP;
        repeat (10) @(posedge clk);
    endtask : deep_pd
endmodule : sdb_ctl_model
`default_nettype wire

// ==== verif/sdb_init_mode_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdb_init_mode_tb;
    import sdb_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, datO, rdat;
    logic ack, done, bv, ckeP;
    logic [3:0] cmdP;
    logic [1:0] baP;
    logic [13:0] aP;
    logic [9:0] col;
    logic [2:0] lat;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    sdb_ctl_model sdb_ctl_model_inst (.clk(clk), .cke(ckeP),
        .cmdPins(cmdP), .bankAddr(baP), .addrPins(aP));
    sdb_init_mode sdb_init_mode_inst (.clk(clk), .reset(reset),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack),
        .cke(ckeP), .cmdPins(cmdP), .bankAddr(baP), .addrPins(aP),
        .initDone(done), .burstValid(bv), .burstCol(col),
        .read_latency_cycles(lat));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 40000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what, seen,
                exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && t < 50)
        begin
            @(posedge clk);
            t++;
        end
        rdat = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        check(ack, 1'b1, "bus ack");
    endtask : wb
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_ready;
        int t;
        t = 0;
        while (done !== 1'b1 && t < 50)
        begin
            @(posedge clk);
            t++;
        end
        check(done, 1'b1, "init done");
    endtask : wait_ready
    task automatic burst(input logic [6:0] mode, input logic [9:0] st);
        logic [9:0] m, e;
        int t;
        m = (10'h001 << mode[2:0]) - 10'h001;
        t = 0;
        sdb_ctl_model_inst.send(CMD_PRE, 2'h0, 14'h0400, 2);
        sdb_ctl_model_inst.send(CMD_MODE, BA_MODE, {7'h00, mode}, 2);
        check(lat, mode[6:4], "latency");
        rd(REG_MODE);
        check(rdat, {25'h0, mode}, "mode reg");
        sdb_ctl_model_inst.send(CMD_ACT, 2'h1, 14'h0123, 4);
        fork
            sdb_ctl_model_inst.send(CMD_READ, 2'h1, {4'h0, st}, 30);
            begin
                while (bv !== 1'b1 && t < 20)
                begin
                    @(posedge clk);
                    t++;
                end
                for (int k = 0; k <= int'(m); k++)
                begin
                    e = mode[3] ? (st ^ 10'(k))
                        : ((st & ~m) | ((st + 10'(k)) & m));
                    check(col, e, "burst column");
                    check(bv, 1'b1, "burst valid");
                    @(posedge clk);
                end
                check(bv, 1'b0, "burst end");
            end
        join
    endtask : burst
    task automatic test_init;
        check(done, 1'b0, "ready at reset");
        rd(REG_MODE);
        check(rdat, {18'h0, MODE_RESET}, "mode at reset");
        wb(1'b1, 8'h40, 32'hffffffff);
        rd(8'h40);
        check(rdat, 32'h0, "unmapped read");
        repeat (20) @(posedge clk);
        // command issued inside the startup wait on purpose
        sdb_ctl_model_inst.send(CMD_PRE, 2'h0, 14'h0400, 2);
        rd(REG_STATUS);
        check(rdat[ST_TIMEERR], 1'b1, "timing error");
        wb(1'b1, REG_CTRL, 32'h3);
        sdb_ctl_model_inst.init(6);
        check(done, 1'b0, "ready before mode load");
        sdb_ctl_model_inst.send(CMD_MODE, BA_MODE, 14'h0032, 2);
        wait_ready();
        rd(REG_STATUS);
        check(rdat[6:0], 7'h0d, "status after init");
        check(lat, 3'h3, "latency after init");
        $display("test init done");
    endtask : test_init
    task automatic test_modes;
        logic [13:0] bad [4] = '{14'h00b2, 14'h0035, 14'h0012, 14'h0030};
        for (int i = 0; i < 8; i++)
            burst({i[1] ? CL3 : CL2, i[0], 3'(i / 2 + 1)},
                10'h2b0 | 10'(3 * i + 5));
        sdb_ctl_model_inst.send(CMD_MODE, BA_EXT, 14'h0020, 2);
        rd(REG_EXT);
        check(rdat, 32'h20, "ext reg");
        foreach (bad[j])
        begin
            sdb_ctl_model_inst.send(CMD_MODE, BA_MODE, bad[j], 2);
            rd(REG_MODE);
            check(rdat, 32'h3c, "mode kept");
            rd(REG_STATUS);
            check(rdat[ST_RESVERR], 1'b1, "reserved flag");
            wb(1'b1, REG_CTRL, 32'h2);
        end
        check(lat, 3'h3, "latency kept");
        $display("test modes done");
    endtask : test_modes
    task automatic test_deep_pd;
        sdb_ctl_model_inst.deep_pd();
        check(done, 1'b0, "ready in deep power-down");
        rd(REG_MODE);
        check(rdat, {18'h0, MODE_RESET}, "mode cleared");
        rd(REG_STATUS);
        check(rdat[ST_DEEPPD], 1'b1, "deep power-down flag");
        sdb_ctl_model_inst.init(0);
        sdb_ctl_model_inst.send(CMD_MODE, BA_MODE, 14'h0021, 2);
        wait_ready();
        burst(7'h3b, 10'h3ff);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        check(done, 1'b0, "ready after reset");
        check(lat, 3'h0, "latency after reset");
        reset <= 1'b0;
        $display("test deep power-down done");
    endtask : test_deep_pd
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        test_init();
        test_modes();
        test_deep_pd();
        give_verdict();
    end
endmodule : sdb_init_mode_tb
`default_nettype wire
